/* rtl/psm_ctrl.sv */
// Power saving mode control: idle, power-down and standby clock gating.
// Assumes the core drives the write strobes and wake inputs on clk.
// Operation
// - Idle request keeps oscillator, gates CPU, acquisition and display clocks.
// - Idle keeps memory, I2C, timer, watchdog and PWM clocks running.
// - Idle freezes CPU, registers, RAM and output pin levels.
// - Enabled interrupt clears idle request, ends idle, interrupt is serviced.
// - Configured software ADC compare interrupt also ends idle.
// - Hardware reset held 24 clocks completes reset and leaves idle.
// - Hardware reset initialises registers and display memory, PC to zero.
// - Power-down request stops the crystal oscillator.
// - Power-down retains registers and data memory, loses auxiliary/display memory.
// - External level interrupt wakes power-down without a clock.
// - Configured software ADC compare interrupt also ends power-down.
// - Hardware reset ends power-down, initialises registers, PC to zero.
// - Standby bit 7 of ROM bank register disables acquisition and display only.
// - Standby combines with idle or power-down and persists after wake.
// - Watchdog disabled only by writing 55h to the watchdog key.
// - Watchdog key register is an eight-bit field.
`timescale 1ns/1ps
`include "psm_consts.svh"
module psm_ctrl (
	input  wire logic          clk,             // System clock
	input  wire logic          reset_n,         // Async reset, active low
	input  wire logic          hw_reset_n,      // External hardware reset, active low
	input  wire logic          power_control_wr, // Write strobe for power_control_reg
	input  wire logic          idle_req_in,     // Written idle_request_bit
	input  wire logic          pdown_req_in,    // Written powerdown_request_bit
	input  wire logic          rom_bank_wr,     // Write strobe for rom_bank_reg
	input  wire logic [7:0]    rom_bank_in,     // Written rom_bank_reg value
	input  wire logic          watchdog_key_wr, // Write strobe for watchdog_key
	input  wire logic [7:0]    watchdog_key_in, // Written watchdog_key value
	input  wire logic          wdt_enable,      // Watchdog is active
	input  wire logic          sadc_wake_en,    // Software ADC compare may wake
	input  wire psm_pkg::psm_wake_t wake,       // Wake interrupt requests
	output logic               idle_request_bit,      // Idle request flag
	output logic               powerdown_request_bit, // Power-down request flag
	output logic               standby,         // Standby bit
	output logic [7:0]         watchdog_key,    // Watchdog key register
	output logic               wdt_disabled,    // Watchdog disabled by key
	output logic               osc_run,         // Crystal oscillator enable
	output psm_pkg::psm_clk_en_t clk_en,        // Per-section clock enables
	output logic               int_service,     // Pulse: wake interrupt to be serviced
	output logic               sys_reset,       // Pulse: hardware reset completed
	output logic               aux_mem_lost     // Auxiliary/display memory invalid
);
	import psm_pkg::*;

	psm_state_t state_q;
	psm_state_t state_d;
	logic [7:0] stab_q;
	logic       reset_done;
	logic       stab_done;
	logic       idle_wake;
	logic       pdown_wake;

	psm_reset_filter u_rst (
		.clk        (clk),
		.reset_n    (reset_n),
		.hw_reset_n (hw_reset_n),
		.reset_done (reset_done)
	);

	assign idle_wake = wake.any_int || (sadc_wake_en && wake.sadc_int);
	assign pdown_wake = wake.ext_int || (sadc_wake_en && wake.sadc_int);
	assign stab_done = (stab_q == 8'(`PSM_STAB_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			PSM_RUN: begin
				if (power_control_wr && pdown_req_in) begin
					state_d = PSM_PDOWN;
				end else if (power_control_wr && idle_req_in) begin
					state_d = PSM_IDLE;
				end
			end
			PSM_IDLE: begin
				if (idle_wake) begin
					state_d = PSM_RUN;
				end
			end
			PSM_PDOWN: begin
				if (pdown_wake) begin
					state_d = PSM_STAB;
				end
			end
			PSM_STAB: begin
				if (stab_done) begin
					state_d = PSM_RUN;
				end
			end
			default: begin
				state_d = PSM_RUN;
			end
		endcase
		if (reset_done) begin
			state_d = PSM_RUN;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= PSM_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stab_q <= 8'h00;
		end else if (state_q == PSM_STAB) begin
			stab_q <= stab_q + 8'h01;
		end else begin
			stab_q <= 8'h00;
		end
	end

	// Request flags: hardware clears on return to run, set by software write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_request_bit      <= 1'b0;
			powerdown_request_bit <= 1'b0;
		end else if (reset_done) begin
			idle_request_bit      <= 1'b0;
			powerdown_request_bit <= 1'b0;
		end else if (power_control_wr && state_q == PSM_RUN) begin
			idle_request_bit      <= idle_req_in && !pdown_req_in;
			powerdown_request_bit <= pdown_req_in;
		end else if (state_d == PSM_RUN && state_q != PSM_RUN) begin
			idle_request_bit      <= 1'b0;
			powerdown_request_bit <= 1'b0;
		end
	end

	// Standby persists across idle/power-down; only software or reset changes it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			standby <= 1'b0;
		end else if (reset_done) begin
			standby <= 1'b0;
		end else if (rom_bank_wr) begin
			standby <= rom_bank_in[`PSM_STANDBY_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_key <= 8'h00;
			wdt_disabled <= 1'b0;
		end else if (reset_done) begin
			watchdog_key <= 8'h00;
			wdt_disabled <= 1'b0;
		end else if (watchdog_key_wr) begin
			watchdog_key <= watchdog_key_in;
			wdt_disabled <= wdt_enable && (watchdog_key_in == `PSM_WDT_KEY_DISABLE);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_mem_lost <= 1'b0;
		end else if (reset_done) begin
			aux_mem_lost <= 1'b0;
		end else if (state_q == PSM_PDOWN) begin
			aux_mem_lost <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			int_service <= 1'b0;
			sys_reset   <= 1'b0;
		end else begin
			int_service <= !reset_done && ((state_q == PSM_IDLE && idle_wake) ||
				(state_q == PSM_STAB && stab_done));
			sys_reset   <= reset_done;
		end
	end

	// Clock gating per section
	always_comb begin
		logic run;
		logic live;
		run  = (state_q == PSM_RUN);
		live = (state_q == PSM_RUN) || (state_q == PSM_IDLE);
		osc_run      = (state_q != PSM_PDOWN);
		clk_en.cpu   = run;
		clk_en.acq   = run && !standby;
		clk_en.disp  = run && !standby;
		clk_en.mem   = live;
		clk_en.i2c   = live;
		clk_en.timer = live;
		clk_en.wdt   = live;
		clk_en.pwm   = live;
		clk_en.sadc  = run;
	end

	property p_pdown_priority;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_RUN && power_control_wr && pdown_req_in && !reset_done) |=>
			state_q == PSM_PDOWN;
	endproperty
	a_pdown_priority: assert property (p_pdown_priority) else $error("no power-down");

	property p_idle_gating;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_IDLE) |-> (osc_run && !clk_en.cpu && !clk_en.disp && !clk_en.acq);
	endproperty
	a_idle_gating: assert property (p_idle_gating) else $error("idle gating wrong");

	property p_idle_live;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_IDLE) |-> (clk_en.mem && clk_en.i2c && clk_en.timer && clk_en.wdt && clk_en.pwm);
	endproperty
	a_idle_live: assert property (p_idle_live) else $error("idle live clocks off");

	property p_idle_wake;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_IDLE && wake.any_int && !reset_done) |=>
			(state_q == PSM_RUN && !idle_request_bit && int_service);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");

	property p_pdown_osc;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_PDOWN) |-> !osc_run;
	endproperty
	a_pdown_osc: assert property (p_pdown_osc) else $error("oscillator in power-down");

	property p_stab_hold;
		@(posedge clk) disable iff (!reset_n)
		(state_q == PSM_PDOWN && pdown_wake && !reset_done) |=>
			(!clk_en.cpu)[*2] ##0 (state_q == PSM_STAB);
	endproperty
	a_stab_hold: assert property (p_stab_hold) else $error("stab too short");

	property p_stab_end;
		@(posedge clk) disable iff (!reset_n)
		$rose(state_q == PSM_STAB) |-> ##[1:200] (state_q == PSM_RUN);
	endproperty
	a_stab_end: assert property (p_stab_end) else $error("stab never ends");

	property p_reset_exit;
		@(posedge clk) disable iff (!reset_n)
		reset_done |=> (state_q == PSM_RUN && sys_reset && !standby);
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("reset exit wrong");

	property p_standby_keep;
		@(posedge clk) disable iff (!reset_n)
		(state_q != PSM_RUN && !rom_bank_wr && !reset_done) |=> $stable(standby);
	endproperty
	a_standby_keep: assert property (p_standby_keep) else $error("standby lost");

	property p_wkey;
		@(posedge clk) disable iff (!reset_n)
		(watchdog_key_wr && !reset_done && watchdog_key_in != `PSM_WDT_KEY_DISABLE) |=>
			!wdt_disabled;
	endproperty
	a_wkey: assert property (p_wkey) else $error("watchdog off by bad key");
endmodule

/* rtl/psm_consts.svh */
// Timing counts, key value and bit positions for the power saving mode control.
// Included by the package and the design files.
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
`define PSM_CLK_PERIOD_NS     100
`define PSM_RST_MIN_CLOCKS    24
`define PSM_STAB_TIME_NS      10000
`define PSM_STAB_CYCLES       ((`PSM_STAB_TIME_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_WDT_KEY_DISABLE   8'h55
`define PSM_STANDBY_BIT       7
`define PSM_RESET_PC          16'h0000
`endif

/* rtl/psm_pkg.sv */
// Types shared by the power saving mode control files.
// Assumes psm_consts.svh sits beside it on the include path.
`include "psm_consts.svh"
package psm_pkg;
	typedef enum logic [2:0] {
		PSM_RUN,
		PSM_IDLE,
		PSM_PDOWN,
		PSM_STAB
	} psm_state_t;

	typedef struct packed {
		logic cpu;
		logic acq;
		logic disp;
		logic mem;
		logic i2c;
		logic timer;
		logic wdt;
		logic pwm;
		logic sadc;
	} psm_clk_en_t;

	typedef struct packed {
		logic ext_int;
		logic sadc_int;
		logic any_int;
	} psm_wake_t;
endpackage

/* rtl/psm_reset_filter.sv */
// Counts how long the external hardware reset has been held.
// Assumes hw_reset_n is synchronous to clk.
`timescale 1ns/1ps
`include "psm_consts.svh"
module psm_reset_filter (
	input  wire logic clk,        // System clock
	input  wire logic reset_n,    // Async reset, active low
	input  wire logic hw_reset_n, // External hardware reset pin, active low
	output logic      reset_done  // Pulse after hold reaches the minimum
);
	logic [4:0] cnt_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 5'h00;
		end else if (hw_reset_n) begin
			cnt_q <= 5'h00;
		end else if (cnt_q != 5'(`PSM_RST_MIN_CLOCKS)) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_done <= 1'b0;
		end else begin
			reset_done <= !hw_reset_n && (cnt_q == 5'(`PSM_RST_MIN_CLOCKS - 1));
		end
	end
endmodule

/* dv/psm_wake_model.sv */
// Wake interrupt sources seen by psm_ctrl.
// Assumes commands arrive as one-cycle pulses on clk from the bench.
`timescale 1ns/1ps
module psm_wake_model (
	input  wire logic          clk,         // System clock
	input  wire logic          reset_n,     // Async reset, active low
	input  wire logic [2:0]    req,         // Command pulse, one bit per source
	input  wire logic          int_service, // Wake accepted by the block
	input  wire logic          sys_reset,   // Hardware reset completed
	output psm_pkg::psm_wake_t wake         // Level wake requests
);
	import psm_pkg::*;
	logic [2:0] pend_q;
	int         delay_q;
	// Requests are levels held until serviced, since no clock runs to catch edges
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= 3'h0;
			delay_q <= 0;
			wake <= '0;
		end else if (int_service || sys_reset) begin
			wake <= '0;
		end else if (req != 3'h0) begin
			pend_q <= req;
			delay_q <= $urandom_range(4, 0);
		end else if (pend_q != 3'h0) begin
			if (delay_q == 0) begin
				wake <= psm_wake_t'(pend_q);
				pend_q <= 3'h0;
			end else begin
				delay_q <= delay_q - 1;
			end
		end
	end
endmodule

/* dv/testbench.sv */
// Self-checking bench for psm_ctrl with the wake source model.
// Assumes a 10 MHz clock; each wake or reset pulse is paired with a queued note.
`timescale 1ns/1ps
`include "psm_consts.svh"
module testbench;
	import psm_pkg::*;
	logic        clk = 1'b0, reset_n = 1'b0, hw_reset_n = 1'b1;
	logic        power_control_wr = 1'b0, idle_req_in = 1'b0, pdown_req_in = 1'b0;
	logic        rom_bank_wr = 1'b0, watchdog_key_wr = 1'b0, wdt_enable = 1'b1;
	logic        sadc_wake_en = 1'b1;
	logic [7:0]  rom_bank_in = 8'h00, watchdog_key_in = 8'h00, watchdog_key, v;
	logic [2:0]  wake_req = 3'h0;
	psm_wake_t   wake;
	psm_clk_en_t clk_en;
	logic        idle_bit, pdown_bit, standby, wdt_disabled, osc_run;
	logic        int_service, sys_reset, aux_mem_lost;
	logic [4:0]  notes[$];
	int          miscompares = 0, checked = 0;
	always #50 clk = ~clk;
	psm_ctrl u_psm_ctrl (.clk(clk), .reset_n(reset_n), .hw_reset_n(hw_reset_n),
		.power_control_wr(power_control_wr), .idle_req_in(idle_req_in),
		.pdown_req_in(pdown_req_in), .rom_bank_wr(rom_bank_wr), .rom_bank_in(rom_bank_in),
		.watchdog_key_wr(watchdog_key_wr), .watchdog_key_in(watchdog_key_in),
		.wdt_enable(wdt_enable), .sadc_wake_en(sadc_wake_en), .wake(wake),
		.idle_request_bit(idle_bit), .powerdown_request_bit(pdown_bit), .standby(standby),
		.watchdog_key(watchdog_key), .wdt_disabled(wdt_disabled), .osc_run(osc_run),
		.clk_en(clk_en), .int_service(int_service), .sys_reset(sys_reset),
		.aux_mem_lost(aux_mem_lost));
	psm_wake_model u_psm_wake_model (.clk(clk), .reset_n(reset_n), .req(wake_req),
		.int_service(int_service), .sys_reset(sys_reset), .wake(wake));
	task automatic complete_run();
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp_gate(input logic [9:0] exp);
		cmp({osc_run, clk_en}, exp, "clock gates");
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_mode(input logic idle, input logic pdown);
		@(posedge clk);
		power_control_wr <= 1'b1;
		idle_req_in <= idle;
		pdown_req_in <= pdown;
		@(posedge clk);
		power_control_wr <= 1'b0;
		#1;
	endtask
	task automatic wr_key(input logic [7:0] k, input logic en);
		@(posedge clk);
		watchdog_key_wr <= 1'b1;
		watchdog_key_in <= k;
		wdt_enable <= en;
		@(posedge clk);
		watchdog_key_wr <= 1'b0;
		tick(1);
	endtask
	task automatic raise(input logic [2:0] m);
		@(posedge clk);
		wake_req <= m;
		@(posedge clk);
		wake_req <= 3'h0;
	endtask
	task automatic hw_hold(input int n);
		@(posedge clk);
		hw_reset_n <= 1'b0;
		repeat (n) @(posedge clk);
		hw_reset_n <= 1'b1;
		#1;
	endtask
	task automatic drain(input int limit);
		for (int i = 0; i < limit && notes.size() != 0; i++)
			@(posedge clk);
		if (notes.size() != 0)
			cmp(10'h3ff, 10'h000, "result missing");
		#1;
	endtask
	// Each service or reset pulse takes the oldest note
	always @(posedge clk) begin
		if (int_service === 1'b1 || sys_reset === 1'b1) begin
			if (notes.size() == 0)
				cmp(10'h3ff, 10'h000, "unexpected pulse");
			else
				cmp({5'h00, sys_reset, int_service, standby, idle_bit, pdown_bit},
					{5'h00, notes.pop_front()}, "result");
		end
	end
	initial begin
		#2_000_000;
		miscompares++;
		complete_run();
	end
	initial begin
		void'($urandom(98));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		tick(1);
		cmp_gate(10'h3ff);
		cmp({aux_mem_lost, wdt_disabled, watchdog_key}, 10'h000, "reset state");
		// Software stand-in turns the watchdog off before idle
		wr_key(8'h55, 1'b1);
		// Idle woken by an enabled interrupt, then by the ADC compare
		for (int s = 0; s < 2; s++) begin
			wr_mode(1'b1, 1'b0);
			cmp_gate(10'h23e);
			cmp({8'h00, idle_bit, pdown_bit}, 10'h002, "idle flag");
			notes.push_back(5'h08);
			raise(s ? 3'b010 : 3'b001);
			drain(20);
			cmp_gate(10'h3ff);
		end
		// ADC compare must not end idle while its wake is not configured
		@(posedge clk);
		sadc_wake_en <= 1'b0;
		wr_mode(1'b1, 1'b0);
		raise(3'b010);
		tick(10);
		cmp_gate(10'h23e);
		notes.push_back(5'h08);
		raise(3'b001);
		drain(20);
		@(posedge clk);
		sadc_wake_en <= 1'b1;
		// Power-down, first with idle also set, woken by external then ADC
		for (int s = 0; s < 2; s++) begin
			wr_mode(s == 0, 1'b1);
			cmp_gate(10'h000);
			tick(1);
			cmp({7'h00, idle_bit, pdown_bit, aux_mem_lost}, 10'h003, "pdown flags");
			notes.push_back(5'h08);
			raise(s ? 3'b010 : 3'b100);
			for (int i = 0; i < 10 && osc_run !== 1'b1; i++)
				tick(1);
			cmp_gate(10'h200);
			tick(`PSM_STAB_CYCLES - 1);
			cmp_gate(10'h200);
			tick(1);
			cmp_gate(10'h3ff);
			drain(5);
		end
		// Standby with random low bank bits, kept across idle and power-down
		@(posedge clk);
		rom_bank_wr <= 1'b1;
		rom_bank_in <= 8'h80 | 8'($urandom() & 32'h7f);
		@(posedge clk);
		rom_bank_wr <= 1'b0;
		tick(1);
		cmp_gate(10'h33f);
		wr_mode(1'b1, 1'b0);
		notes.push_back(5'h0c);
		raise(3'b001);
		drain(20);
		cmp_gate(10'h33f);
		wr_mode(1'b0, 1'b1);
		notes.push_back(5'h0c);
		raise(3'b100);
		drain(130);
		cmp_gate(10'h33f);
		// Watchdog key: only the disable value, while active, sets the flag
		for (int i = 0; i < 6; i++) begin
			v = i[0] ? 8'h55 : 8'($urandom());
			if (!i[0] && v == 8'h55)
				v = 8'h54;
			wr_key(v, i < 4);
			cmp({1'b0, watchdog_key, wdt_disabled},
				{1'b0, v, v == 8'h55 && i < 4}, "key");
		end
		// Hardware reset in idle, then power-down: one clock short is ignored in idle, the full hold is enough in both
		wr_key(8'h55, 1'b1);
		wr_mode(1'b1, 1'b0);
		hw_hold(`PSM_RST_MIN_CLOCKS - 1);
		tick(3);
		cmp_gate(10'h23e);
		notes.push_back(5'h10);
		hw_hold(`PSM_RST_MIN_CLOCKS);
		drain(5);
		cmp_gate(10'h3ff);
		cmp({aux_mem_lost, wdt_disabled, watchdog_key}, 10'h000, "reset state");
		wr_mode(1'b0, 1'b1);
		notes.push_back(5'h10);
		hw_hold(`PSM_RST_MIN_CLOCKS);
		drain(5);
		tick(2);
		cmp_gate(10'h3ff);
		complete_run();
	end
endmodule
